// >>> common/pxb_pkg.sv
/*
 * Shared constants and carrier types of the priority pin crossbar.
 * Assumes a 32-bit AHB-Lite register bus and an 8-pin byte-wide port.
 */
package pxb_pkg;

    // ----------------------------------------------------------------
    // port geometry
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 8;
    localparam int SKIP_BITS = 7;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SKIP_MASK   = 8'h00;
    localparam logic [7:0] OFS_FUNC_SEL_A  = 8'h04;
    localparam logic [7:0] OFS_FUNC_SEL_B  = 8'h08;
    localparam logic [7:0] OFS_OUT_MODE    = 8'h0C;
    localparam logic [7:0] OFS_IN_MODE     = 8'h10;
    localparam logic [7:0] OFS_PORT_LATCH  = 8'h14;
    localparam logic [7:0] OFS_PORT_PINS   = 8'h18;
    localparam int         ADDR_LSB_USED   = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] RST_SKIP_MASK   = 7'h00;
    localparam logic [7:0] RST_FUNC_SEL_A  = 8'h00;
    localparam logic [7:0] RST_FUNC_SEL_B  = 8'h00;
    localparam logic [7:0] RST_OUT_MODE    = 8'h00;
    localparam logic [7:0] RST_IN_MODE     = 8'hFF;
    localparam logic [7:0] RST_PORT_LATCH  = 8'hFF;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SEL_A_UTX      = 0;
    localparam int SEL_A_URX      = 1;
    localparam int SEL_A_SMB      = 2;
    localparam int SEL_A_SYSCLK   = 3;
    localparam int SEL_A_CMP      = 4;
    localparam int SEL_A_CMP_ASYN = 5;
    localparam int SEL_A_CEX_LO   = 6;
    localparam int SEL_A_CEX_HI   = 7;
    localparam int SEL_B_XBAR_EN  = 6;

    // ----------------------------------------------------------------
    // fixed uart pins and counter route codes
    // ----------------------------------------------------------------
    localparam int         UART_TX_PIN = 4;
    localparam int         UART_RX_PIN = 5;
    localparam logic [1:0] CEX_NONE    = 2'h0;
    localparam logic [1:0] CEX_ONE     = 2'h1;
    localparam logic [1:0] CEX_TWO     = 2'h2;

    // ----------------------------------------------------------------
    // pin function codes, listed in priority order
    // ----------------------------------------------------------------
    typedef logic [3:0] pxb_fn_type;
    localparam pxb_fn_type FN_GPIO   = 4'h0;
    localparam pxb_fn_type FN_UTX    = 4'h1;
    localparam pxb_fn_type FN_URX    = 4'h2;
    localparam pxb_fn_type FN_SDA    = 4'h3;
    localparam pxb_fn_type FN_SCL    = 4'h4;
    localparam pxb_fn_type FN_CMP    = 4'h5;
    localparam pxb_fn_type FN_CMPA   = 4'h6;
    localparam pxb_fn_type FN_SYSCLK = 4'h7;
    localparam pxb_fn_type FN_CEX0   = 4'h8;
    localparam pxb_fn_type FN_CEX1   = 4'h9;
    localparam pxb_fn_type FN_CEX2   = 4'hA;
    localparam int         FN_FIRST_SCANNED = 3;
    localparam int         FN_LAST          = 10;

    // ----------------------------------------------------------------
    // AHB-Lite codes
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // ----------------------------------------------------------------
    // carriers between peripherals and crossbar
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       utx;
        logic       sda;
        logic       scl;
        logic       cmp;
        logic       cmp_asyn;
        logic       sysclk;
        logic [2:0] cex;
    } pxb_drive_type;

    typedef struct packed {
        logic       urx;
        logic       sda;
        logic       scl;
        logic [2:0] cex;
    } pxb_sense_type;

endpackage

// >>> rtl/pxb_crossbar.sv
/*
 * Priority pin crossbar with AHB-Lite register slave.
 * Assumes one clock, synchronous pin inputs and a pad ring that resolves
 * each pin from its output and output enable.
 */
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module pxb_crossbar
    import pxb_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          hsel_i,
    input  wire logic [31:0]   haddr_i,
    input  wire logic [1:0]    htrans_i,
    input  wire logic          hwrite_i,
    input  wire logic [2:0]    hsize_i,
    input  wire logic [31:0]   hwdata_i,
    input  wire logic          hready_i,
    output logic      [31:0]   hrdata_o,
    output logic               hreadyout_o,
    output logic               hresp_o,
    input  wire pxb_drive_type drive_i,
    output pxb_sense_type      sense_o,
    input  wire logic [7:0]    pin_in_i,
    output logic      [7:0]    pin_out_o,
    output logic      [7:0]    pin_oe_o
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [6:0]       pin_skip_mask_reg;
    logic [7:0]       function_select_a_reg;
    logic [7:0]       function_select_b_reg;
    logic [7:0]       port_output_mode_reg;
    logic [7:0]       port_input_mode_reg;
    logic [7:0]       port_latch_reg;
    logic             wr_pend_reg;
    logic             rd_pend_reg;
    logic [7:0]       addr_reg;
    logic             crossbar_enable_bit;
    logic [1:0]       counter_array_route_field;
    logic [10:0]      want;
    pxb_fn_type       fn_map   [PIN_COUNT];
    logic [7:0]       taken;
    logic [7:0]       assigned_vec;
    logic [7:0]       od_vec;
    logic [7:0]       val_vec;
    logic [7:0]       oe_next;
    logic [7:0]       out_next;
    pxb_sense_type    sense_next;
    logic [31:0]      rd_value;

    assign crossbar_enable_bit       = function_select_b_reg[SEL_B_XBAR_EN];
    assign counter_array_route_field = function_select_a_reg[SEL_A_CEX_HI:SEL_A_CEX_LO];

    // ----------------------------------------------------------------
    // AHB-Lite slave: writes zero wait, reads one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
                wr_pend_reg <= hwrite_i;
                rd_pend_reg <= !hwrite_i;
                addr_reg    <= haddr_i[ADDR_LSB_USED-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= HRESP_OKAY;
        end else begin
            hresp_o     <= HRESP_OKAY;
            hreadyout_o <= !(hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i);
        end
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (addr_reg)
            OFS_SKIP_MASK:  rd_value[SKIP_BITS-1:0] = pin_skip_mask_reg;
            OFS_FUNC_SEL_A: rd_value[7:0] = function_select_a_reg;
            OFS_FUNC_SEL_B: rd_value[7:0] = function_select_b_reg;
            OFS_OUT_MODE:   rd_value[7:0] = port_output_mode_reg;
            OFS_IN_MODE:    rd_value[7:0] = port_input_mode_reg;
            OFS_PORT_LATCH: rd_value[7:0] = port_latch_reg;
            OFS_PORT_PINS:  rd_value[7:0] = pin_in_i;
            default:        rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_o <= rd_value;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pin_skip_mask_reg     <= RST_SKIP_MASK;
            function_select_a_reg <= RST_FUNC_SEL_A;
            function_select_b_reg <= RST_FUNC_SEL_B;
            port_output_mode_reg  <= RST_OUT_MODE;
            port_input_mode_reg   <= RST_IN_MODE;
            port_latch_reg        <= RST_PORT_LATCH;
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                OFS_SKIP_MASK:  pin_skip_mask_reg     <= hwdata_i[SKIP_BITS-1:0];
                OFS_FUNC_SEL_A: function_select_a_reg <= hwdata_i[7:0];
                OFS_FUNC_SEL_B: function_select_b_reg <= hwdata_i[7:0];
                OFS_OUT_MODE:   port_output_mode_reg  <= hwdata_i[7:0];
                OFS_IN_MODE:    port_input_mode_reg   <= hwdata_i[7:0];
                OFS_PORT_LATCH: port_latch_reg        <= hwdata_i[7:0];
                default:        ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // function requests
    // ----------------------------------------------------------------
    always_comb begin
        want                 = '0;
        want[FN_UTX]         = function_select_a_reg[SEL_A_UTX];
        want[FN_URX]         = function_select_a_reg[SEL_A_URX];
        want[FN_SDA]         = function_select_a_reg[SEL_A_SMB];
        want[FN_SCL]         = function_select_a_reg[SEL_A_SMB];
        want[FN_CMP]         = function_select_a_reg[SEL_A_CMP];
        want[FN_CMPA]        = function_select_a_reg[SEL_A_CMP_ASYN];
        want[FN_SYSCLK]      = function_select_a_reg[SEL_A_SYSCLK];
        want[FN_CEX0]        = counter_array_route_field != CEX_NONE;
        want[FN_CEX1]        = counter_array_route_field != CEX_NONE
                             && counter_array_route_field != CEX_ONE;
        want[FN_CEX2]        = counter_array_route_field != CEX_NONE
                             && counter_array_route_field != CEX_ONE
                             && counter_array_route_field != CEX_TWO;
    end

    // ----------------------------------------------------------------
    // priority decode
    // ----------------------------------------------------------------
    always_comb begin
        logic found;
        found = 1'b0;
        taken = {1'b0, pin_skip_mask_reg};
        for (int p = 0; p < PIN_COUNT; p++) begin
            fn_map[p] = FN_GPIO;
        end
        if (want[FN_UTX]) begin
            fn_map[UART_TX_PIN] = FN_UTX;
            taken[UART_TX_PIN]  = 1'b1;
        end
        if (want[FN_URX]) begin
            fn_map[UART_RX_PIN] = FN_URX;
            taken[UART_RX_PIN]  = 1'b1;
        end
        for (int f = FN_FIRST_SCANNED; f <= FN_LAST; f++) begin
            found = 1'b0;
            if (want[f]) begin
                for (int p = 0; p < PIN_COUNT; p++) begin
                    if (!found && !taken[p]) begin
                        fn_map[p] = pxb_fn_type'(f);
                        taken[p]  = 1'b1;
                        found     = 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive and sense selection
    // ----------------------------------------------------------------
    always_comb begin
        sense_next = '{urx: 1'b1, sda: 1'b1, scl: 1'b1, cex: 3'h0};
        for (int p = 0; p < PIN_COUNT; p++) begin
            assigned_vec[p] = fn_map[p] != FN_GPIO;
            od_vec[p]       = !port_output_mode_reg[p]
                            || fn_map[p] == FN_SDA || fn_map[p] == FN_SCL;
            unique case (fn_map[p])
                FN_UTX:    val_vec[p] = drive_i.utx;
                FN_SDA:    val_vec[p] = drive_i.sda;
                FN_SCL:    val_vec[p] = drive_i.scl;
                FN_CMP:    val_vec[p] = drive_i.cmp;
                FN_CMPA:   val_vec[p] = drive_i.cmp_asyn;
                FN_SYSCLK: val_vec[p] = drive_i.sysclk;
                FN_CEX0:   val_vec[p] = drive_i.cex[0];
                FN_CEX1:   val_vec[p] = drive_i.cex[1];
                FN_CEX2:   val_vec[p] = drive_i.cex[2];
                default:   val_vec[p] = port_latch_reg[p];
            endcase
            if (!crossbar_enable_bit || !port_input_mode_reg[p]
                || fn_map[p] == FN_URX) begin
                oe_next[p]  = 1'b0;
                out_next[p] = 1'b0;
            end else if (od_vec[p]) begin
                oe_next[p]  = !val_vec[p];
                out_next[p] = 1'b0;
            end else begin
                oe_next[p]  = 1'b1;
                out_next[p] = val_vec[p];
            end
            if (crossbar_enable_bit) begin
                unique case (fn_map[p])
                    FN_URX:  sense_next.urx    = pin_in_i[p];
                    FN_SDA:  sense_next.sda    = pin_in_i[p];
                    FN_SCL:  sense_next.scl    = pin_in_i[p];
                    FN_CEX0: sense_next.cex[0] = pin_in_i[p];
                    FN_CEX1: sense_next.cex[1] = pin_in_i[p];
                    FN_CEX2: sense_next.cex[2] = pin_in_i[p];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pin_oe_o  <= 8'h00;
            pin_out_o <= 8'h00;
            sense_o   <= '{urx: 1'b1, sda: 1'b1, scl: 1'b1, cex: 3'h0};
        end else begin
            pin_oe_o  <= oe_next;
            pin_out_o <= out_next;
            sense_o   <= sense_next;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    logic [7:0] free_base;
    logic [7:0] lowest_free;
    logic [7:0] sda_at;
    logic [7:0] scl_at;
    logic [7:0] cex0_at;
    logic [7:0] cex1_at;
    logic [7:0] cex2_at;

    // pins left for the scanned functions once skips and uart are out
    always_comb begin
        free_base = ~{1'b0, pin_skip_mask_reg};
        if (want[FN_UTX]) begin
            free_base[UART_TX_PIN] = 1'b0;
        end
        if (want[FN_URX]) begin
            free_base[UART_RX_PIN] = 1'b0;
        end
    end
    assign lowest_free = free_base & (~free_base + 8'h01);

    // one-hot pin position of bus data, bus clock and each counter channel
    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            sda_at[p]  = fn_map[p] == FN_SDA;
            scl_at[p]  = fn_map[p] == FN_SCL;
            cex0_at[p] = fn_map[p] == FN_CEX0;
            cex1_at[p] = fn_map[p] == FN_CEX1;
            cex2_at[p] = fn_map[p] == FN_CEX2;
        end
    end

    sequence seq_pin_read_addr;
        hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i
        && haddr_i[ADDR_LSB_USED-1:0] == OFS_PORT_PINS;
    endsequence
    sequence seq_wait_then_ready;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    AST_DISABLED_NO_DRIVE: assert property (!crossbar_enable_bit |=> pin_oe_o == 8'h00)
        else $error("pin driven while crossbar disabled");
    AST_DISABLED_SENSE_IDLE: assert property (!crossbar_enable_bit
        |=> sense_o.urx && sense_o.sda && sense_o.scl && sense_o.cex == 3'h0)
        else $error("peripheral input not idle while crossbar disabled");
    AST_SKIP_NEVER_ASSIGNED: assert property
        ((assigned_vec[SKIP_BITS-1:0] & pin_skip_mask_reg) == 7'h00)
        else $error("skipped pin received a function");
    AST_TX_FIXED: assert property (want[FN_UTX] |-> fn_map[UART_TX_PIN] == FN_UTX)
        else $error("uart transmit not on its fixed pin");
    AST_RX_FIXED: assert property (want[FN_URX] |-> fn_map[UART_RX_PIN] == FN_URX)
        else $error("uart receive not on its fixed pin");
    AST_RX_NO_DRIVE: assert property (want[FN_URX] |=> !pin_oe_o[UART_RX_PIN])
        else $error("uart receive pin driven");
    AST_RX_SENSE: assert property (crossbar_enable_bit && want[FN_URX]
        |=> sense_o.urx == $past(pin_in_i[UART_RX_PIN]))
        else $error("uart receive not taken from its fixed pin");
    AST_LOWEST_FREE: assert property (want[FN_SDA] && free_base != 8'h00
        |-> sda_at == lowest_free)
        else $error("bus data did not take the lowest free pin");
    AST_PAIR_PLACED: assert property (want[FN_SDA] && $countones(free_base) >= 2
        |-> $countones(sda_at) == 1 && $countones(scl_at) == 1 && scl_at > sda_at)
        else $error("bus data and clock not placed as a pair");
    AST_OPEN_DRAIN: assert property (##1 (pin_oe_o & pin_out_o & $past(od_vec)) == 8'h00)
        else $error("open-drain pin driven high");
    AST_ANALOG_NO_DRIVE: assert property (##1
        (pin_oe_o & ~$past(port_input_mode_reg)) == 8'h00)
        else $error("analog pin driven");
    AST_PUSH_PULL: assert property (crossbar_enable_bit && port_output_mode_reg[0]
        && port_input_mode_reg[0] && fn_map[0] == FN_GPIO
        |=> pin_oe_o[0] && pin_out_o[0] == $past(port_latch_reg[0]))
        else $error("push-pull gpio pin not driven from latch");
    AST_CEX_COUNT: assert property ($countones(cex2_at) <= 1
        and (!(&counter_array_route_field) |-> cex2_at == 8'h00))
        else $error("counter channel routed beyond field");
    AST_CEX_ORDER: assert property (cex1_at != 8'h00
        |-> cex0_at != 8'h00 && cex1_at > cex0_at)
        else $error("counter channels out of priority order");
    AST_PIN_READ: assert property (seq_pin_read_addr ##1 seq_wait_then_ready
        |-> hrdata_o[7:0] == $past(pin_in_i))
        else $error("pin read returned wrong level");

endmodule

// >>> bench/pxb_board.sv
/*
 * Board model for the port pins: pull-ups on every pin, optional external drivers.
 * Assumes pin_oe_i high while the crossbar drives the pin.
 */
`timescale 1ns/1ps
module pxb_board (
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pin_level_o
);
    // released pins float up, so open-drain ones read high
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pin_level_o[n] = pin_oe_i[n] ? pin_out_i[n] : (ext_en_i[n] ? ext_val_i[n] : 1'b1);
        end
    end
endmodule

// >>> bench/priority_pin_crossbar_bench.sv
/*
 * Self-checking bench of the priority pin crossbar: AHB-Lite register access and routing.
 * Assumes the board model resolves each pin and pulls released pins high.
 */
`timescale 1ns/1ps
module priority_pin_crossbar_bench
    import pxb_pkg::*;
;
    logic          sys_clk, nrst, hsel, hwrite, hready, hresp;
    logic [1:0]    htrans;
    logic [31:0]   haddr, hwdata, hrdata, q;
    pxb_drive_type drv;
    pxb_sense_type sense;
    logic [7:0]    pin_lvl, pin_out, pin_oe, ext_en, ext_val;
    int            err_total, num_checks;

    pxb_crossbar pxb_crossbar_inst (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .drive_i(drv), .sense_o(sense), .pin_in_i(pin_lvl), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe));
    pxb_board pxb_board_inst (
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_level_o(pin_lvl));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) begin
            $display("mismatch hready expected 1 seen timeout");
            err_total++;
            give_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, q);
    endtask

    // two edges: one for the routing to settle, one to sample it
    task automatic pins(input logic [7:0] eoe, input logic [7:0] eout);
        repeat (2) @(posedge sys_clk);
        chk("pin_oe", {24'h0, eoe}, {24'h0, pin_oe});
        chk("pin_out", {24'h0, eout}, {24'h0, pin_out});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdchk("skip", OFS_SKIP_MASK, 32'h00000000);
        rdchk("sel_a", OFS_FUNC_SEL_A, 32'h00000000);
        rdchk("sel_b", OFS_FUNC_SEL_B, 32'h00000000);
        rdchk("out_mode", OFS_OUT_MODE, 32'h00000000);
        rdchk("in_mode", OFS_IN_MODE, 32'h000000FF);
        rdchk("latch", OFS_PORT_LATCH, 32'h000000FF);
        rdchk("unmapped", 8'h1C, 32'h00000000);
        bus(1'b1, OFS_SKIP_MASK, 32'hFFFFFFFF);
        rdchk("skip_top", OFS_SKIP_MASK, 32'h0000007F);
        bus(1'b1, OFS_SKIP_MASK, 32'h00000000);
        pins(8'h00, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_uart();
        bus(1'b1, OFS_OUT_MODE, 32'h00000010);
        bus(1'b1, OFS_FUNC_SEL_A, 32'h00000001);
        bus(1'b1, OFS_FUNC_SEL_B, 32'h00000040);
        drv <= pxb_drive_type'(9'b0_0_0_0_0_0_000);
        pins(8'h10, 8'h00);
        drv <= pxb_drive_type'(9'b1_0_0_0_0_0_000);
        pins(8'h10, 8'h10);
        bus(1'b1, OFS_FUNC_SEL_A, 32'h00000002);
        ext_en  <= 8'h20;
        ext_val <= 8'h00;
        pins(8'h10, 8'h10);
        chk("urx_low", 32'h0, {31'h0, sense.urx});
        ext_val <= 8'h20;
        repeat (2) @(posedge sys_clk);
        chk("urx_high", 32'h1, {31'h0, sense.urx});
        ext_en <= 8'h00;
        $display("test uart done");
    endtask

    task automatic t_prio();
        bus(1'b1, OFS_FUNC_SEL_B, 32'h00000000);
        bus(1'b1, OFS_SKIP_MASK, 32'h00000044);
        bus(1'b1, OFS_OUT_MODE, 32'h000000BB);
        bus(1'b1, OFS_FUNC_SEL_A, 32'h000000DD);
        drv <= pxb_drive_type'(9'b1_0_0_1_0_0_111);
        pins(8'h00, 8'h00);
        bus(1'b1, OFS_FUNC_SEL_B, 32'h00000040);
        pins(8'hBB, 8'h98);
        rdchk("pin_read", OFS_PORT_PINS, 32'h000000DC);
        chk("bus_sense", 32'h0, {30'h0, sense.sda, sense.scl});
        chk("cex_sense", 32'h1, {29'h0, sense.cex});
        drv <= pxb_drive_type'(9'b0_1_0_0_0_1_000);
        pins(8'hBA, 8'h20);
        drv <= pxb_drive_type'(9'b1_0_0_1_0_0_111);
        bus(1'b1, OFS_OUT_MODE, 32'h00000000);
        pins(8'h23, 8'h00);
        bus(1'b1, OFS_PORT_LATCH, 32'h00000000);
        pins(8'h67, 8'h00);
        bus(1'b1, OFS_PORT_LATCH, 32'h000000FF);
        $display("test priority done");
    endtask

    task automatic t_pair();
        bus(1'b1, OFS_FUNC_SEL_A, 32'h00000024);
        bus(1'b1, OFS_SKIP_MASK, 32'h0000007F);
        drv <= pxb_drive_type'(9'b0_0_0_0_1_0_000);
        pins(8'h80, 8'h00);
        $display("test pair done");
    endtask

    task automatic t_cex();
        logic [7:0] e;
        bus(1'b1, OFS_SKIP_MASK, 32'h00000000);
        bus(1'b1, OFS_OUT_MODE, 32'h00000007);
        bus(1'b1, OFS_PORT_LATCH, 32'h00000000);
        drv <= pxb_drive_type'(9'b0_1_1_0_0_0_111);
        for (int c = 0; c < 4; c++) begin
            e = 8'((1 << c) - 1);
            bus(1'b1, OFS_FUNC_SEL_A, {24'h0, 2'(c), 6'h00});
            pins(8'hFF, e);
        end
        bus(1'b1, OFS_IN_MODE, 32'h000000FE);
        pins(8'hFE, 8'h06);
        $display("test counter route done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        drv = '0;
        ext_en = 8'h00;
        ext_val = 8'h00;
        err_total = 0;
        num_checks = 0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_uart();
        t_prio();
        t_pair();
        t_cex();
        give_verdict();
    end
endmodule
